// ===== core/ssc_pkg.sv
/*
 * ssc_pkg: shared constants for the stack and segment compatibility block.
 * Holds register offsets, field positions, reset values, the core variant
 * enumeration and the stack command codes. Assumes 32-bit AXI4-Lite access.
 */
package ssc_pkg;

   // core variant, fixed at build time
   typedef enum logic [1:0] {
      VAR_LATER  = 2'h0,
      VAR_ALT    = 2'h1,
      VAR_LEGACY = 2'h3
   } ssc_variant_t;

   // command codes written into the command register
   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_PUSH_SEL = 3'h1,
      OP_POP_SEL  = 3'h3,
      OP_PUSH_ERR = 3'h2,
      OP_FAR_CALL = 3'h6,
      OP_GATE_CLL = 3'h7,
      OP_GATE_RET = 3'h5,
      OP_POP_MEM  = 3'h4
   } ssc_op_t;

   // register byte offsets
   localparam logic [7:0] OFS_CR0    = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_ESP    = 8'h08;
   localparam logic [7:0] OFS_ARG    = 8'h0C;
   localparam logic [7:0] OFS_AUX    = 8'h10;
   localparam logic [7:0] OFS_DLO    = 8'h14;
   localparam logic [7:0] OFS_DHI    = 8'h18;
   localparam logic [7:0] OFS_BASE   = 8'h1C;
   localparam logic [7:0] OFS_LIMIT  = 8'h20;
   localparam logic [7:0] OFS_MADDR  = 8'h24;
   localparam logic [7:0] OFS_MDATA  = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   localparam logic [7:0] OFS_NJMP   = 8'h30;

   // field positions
   localparam int CR0_PG_BIT   = 31;
   localparam int CMD_OP32_BIT = 3;
   localparam int AUX_BRF_BIT  = 0;
   localparam int AUX_PGB_BIT  = 1;
   localparam int DHI_G_BIT    = 23;
   localparam int DHI_DB_BIT   = 22;
   localparam int DHI_S_BIT    = 12;
   localparam int DHI_WIDE_BIT = 11;

   // reset values
   localparam logic [31:0] CR0_RST = 32'h0000_0000;
   localparam logic [31:0] ESP_RST = 32'h0000_0000;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== core/ssc_compat_core.sv
/*
 * ssc_compat_core: stack and segment compatibility logic of a processor
 * core, reached over AXI4-Lite. Software writes a stack command and its
 * operands; the block computes the new stack pointer, the memory access
 * it implies (offset, byte count, data) and any fault, and decodes a
 * segment descriptor. Assumes one clock, synchronous reset, and a master
 * that follows AXI4-Lite handshakes.
 */
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// - paging_on_flag follows the paging bit written into control_reg_zero
// - later variant: control_write_instr serializes, paging changes at once
// - default variant selector push: pointer minus operand size, 2 bytes written
// - alternative variant selector push writes operand size, upper bytes zero
// - selector pop reads 2 bytes (alternative: operand size), pointer advances
// - alternative variant faults if bytes 3 or 4 exceed limit or page bad
// - pop-to-memory wrapping 16-bit pointer writes to offset zero plus index
// - on a 32-bit stack error code pushed as 32 bits, upper half zero, pointer minus 4 (16-bit stack: 2 bytes, minus 2)
// - legacy variant writes 2 error-code bytes but still lowers pointer by 4
// - later variant checks far-call branch target before any push
// - branch fault restores pointer to its value before the instruction
// - call through 16-bit gate saves only low 16 pointer bits
// - return into 32-bit stack zero-fills upper pointer half
// - legacy variant fills upper pointer half with stack selector
// - size flag picks 16- or 32-bit segment and stack width
// - clear reserved descriptor word forces base upper 8 bits zero
// - clear reserved word forces upper 4 limit bits zero
// - clear granularity flag means limit counts single bytes
// - 16-bit stack uses narrow_stack_pointer and 64-Kbyte limit
// - 16-bit and 32-bit gate and task descriptors both accepted
module ssc_compat_core #(
   parameter ssc_pkg::ssc_variant_t VARIANT = ssc_pkg::VAR_LATER
) (
   // clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // axi write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // address translation state
   output logic             paging_on_flag
);

   localparam bit IS_LATER  = (VARIANT == ssc_pkg::VAR_LATER);
   localparam bit IS_ALT    = (VARIANT == ssc_pkg::VAR_ALT);
   localparam bit IS_LEGACY = (VARIANT == ssc_pkg::VAR_LEGACY);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic        aw_full_reg, w_full_reg, aw_rdy_reg, w_rdy_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg, ar_rdy_reg, rvalid_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rd_mux;
   logic        rd_hit, wr_hit;
   logic        wr_fire;
   logic [31:0] cr0_reg, esp_reg, arg_reg, aux_reg;
   logic [31:0] dlo_reg, dhi_reg, base_reg, limit_reg;
   logic [31:0] maddr_reg, mdata_reg;
   logic [3:0]  mbytes_reg;
   logic        fault_reg, pg_reg, db_reg, wide_gate_reg, legacy_desc_reg;
   logic [3:0]  cmd_reg;
   logic [31:0] cr0_wr;
   // execution results
   logic [31:0] esp_next, maddr_next, mdata_next, step, dec, inc;
   logic [3:0]  mbytes_next;
   logic        fault_next, do_cmd, op32, wide_sel, far_end_bad;
   ssc_pkg::ssc_op_t op;
   // descriptor decode
   logic [31:0] base_next, limit_next;
   logic [19:0] lim20;
   logic        dhi_clear;

   // merge write data into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // pointer arithmetic: a 16-bit stack wraps inside narrow_stack_pointer
   function automatic logic [31:0] sp_move(input logic [31:0] sp,
                                           input logic [31:0] d,
                                           input logic        up,
                                           input logic        wide);
      logic [31:0] r;
      r = up ? sp + d : sp - d;
      if (!wide) begin
         r = {sp[31:16], r[15:0]};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel capture, either order accepted

   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_rdy_reg  <= 1'b0;
         w_rdy_reg   <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else if (ce) begin
         // ready drops the cycle after capture so payload stays single
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_rdy_reg  <= 1'b1;
            w_rdy_reg   <= 1'b1;
         end else begin
            if (s_axi_awvalid && aw_rdy_reg) begin
               aw_full_reg <= 1'b1;
               aw_addr_reg <= s_axi_awaddr;
               aw_rdy_reg  <= 1'b0;
            end else begin
               aw_rdy_reg  <= !aw_full_reg;
            end
            if (s_axi_wvalid && w_rdy_reg) begin
               w_full_reg <= 1'b1;
               w_data_reg <= s_axi_wdata;
               w_strb_reg <= s_axi_wstrb;
               w_rdy_reg  <= 1'b0;
            end else begin
               w_rdy_reg  <= !w_full_reg;
            end
         end
      end
   end

   // write response, held until bready
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= ssc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      unique case (aw_addr_reg)
         ssc_pkg::OFS_CR0, ssc_pkg::OFS_CMD, ssc_pkg::OFS_ESP,
         ssc_pkg::OFS_ARG, ssc_pkg::OFS_AUX, ssc_pkg::OFS_DLO,
         ssc_pkg::OFS_DHI, ssc_pkg::OFS_NJMP: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel, answer one cycle after the address

   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         ssc_pkg::OFS_CR0:    rd_mux = cr0_reg;
         ssc_pkg::OFS_CMD:    rd_mux = {28'h0000000, cmd_reg};
         ssc_pkg::OFS_ESP:    rd_mux = esp_reg;
         ssc_pkg::OFS_ARG:    rd_mux = arg_reg;
         ssc_pkg::OFS_AUX:    rd_mux = aux_reg;
         ssc_pkg::OFS_DLO:    rd_mux = dlo_reg;
         ssc_pkg::OFS_DHI:    rd_mux = dhi_reg;
         ssc_pkg::OFS_BASE:   rd_mux = base_reg;
         ssc_pkg::OFS_LIMIT:  rd_mux = limit_reg;
         ssc_pkg::OFS_MADDR:  rd_mux = maddr_reg;
         ssc_pkg::OFS_MDATA:  rd_mux = mdata_reg;
         ssc_pkg::OFS_STATUS: rd_mux = {22'h000000, legacy_desc_reg, wide_gate_reg,
                                        db_reg, pg_reg, fault_reg, 1'b0, mbytes_reg};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ar_rdy_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= ssc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && ar_rdy_reg) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_DECERR;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b1;
         end else if (!rvalid_reg) begin
            ar_rdy_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stack command execution

   always_comb begin
      do_cmd      = wr_fire && (aw_addr_reg == ssc_pkg::OFS_CMD);
      op          = ssc_pkg::ssc_op_t'(w_data_reg[2:0]);
      op32        = w_data_reg[ssc_pkg::CMD_OP32_BIT];
      step        = op32 ? 32'h0000_0004 : 32'h0000_0002;
      dec         = sp_move(esp_reg, step, 1'b0, db_reg);
      inc         = sp_move(esp_reg, step, 1'b1, db_reg);
      wide_sel    = IS_ALT && op32;
      esp_next    = esp_reg;
      maddr_next  = maddr_reg;
      mdata_next  = mdata_reg;
      mbytes_next = mbytes_reg;
      fault_next  = fault_reg;
      far_end_bad = 1'b0;
      unique case (op)
         ssc_pkg::OP_PUSH_SEL: begin
            // bytes three and four only exist for the wide store
            far_end_bad = wide_sel && ((dec + 32'h0000_0003) > limit_reg
                          || aux_reg[ssc_pkg::AUX_PGB_BIT]);
            fault_next  = far_end_bad;
            if (!far_end_bad) begin
               esp_next    = dec;
               maddr_next  = dec;
               mbytes_next = wide_sel ? 4'h4 : 4'h2;
               mdata_next  = {16'h0000, arg_reg[15:0]};
            end
         end
         ssc_pkg::OP_POP_SEL: begin
            far_end_bad = wide_sel && ((esp_reg + 32'h0000_0003) > limit_reg
                          || aux_reg[ssc_pkg::AUX_PGB_BIT]);
            fault_next  = far_end_bad;
            if (!far_end_bad) begin
               esp_next    = inc;
               maddr_next  = esp_reg;
               mbytes_next = wide_sel ? 4'h4 : 4'h2;
               mdata_next  = wide_sel ? arg_reg : {16'h0000, arg_reg[15:0]};
            end
         end
         ssc_pkg::OP_PUSH_ERR: begin
            // error codes follow the stack width, not the operand size
            esp_next    = sp_move(esp_reg, db_reg ? 32'h0000_0004 : 32'h0000_0002,
                                  1'b0, db_reg);
            maddr_next  = esp_next;
            mbytes_next = (IS_LEGACY || !db_reg) ? 4'h2 : 4'h4;
            mdata_next  = {16'h0000, arg_reg[15:0]};
            fault_next  = 1'b0;
         end
         ssc_pkg::OP_FAR_CALL: begin
            fault_next = aux_reg[ssc_pkg::AUX_BRF_BIT];
            maddr_next = sp_move(esp_reg, {step[30:0], 1'b0}, 1'b0, db_reg);
            mdata_next = arg_reg;
            if (aux_reg[ssc_pkg::AUX_BRF_BIT]) begin
               // later variant resolves the target first: nothing stored
               mbytes_next = IS_LATER ? 4'h0 : {step[2:0], 1'b0};
               esp_next    = esp_reg;
            end else begin
               mbytes_next = {step[2:0], 1'b0};
               esp_next    = maddr_next;
            end
         end
         ssc_pkg::OP_GATE_CLL: begin
            // a 16-bit gate has room for only the low half
            mdata_next  = {16'h0000, esp_reg[15:0]};
            maddr_next  = esp_reg;
            mbytes_next = 4'h2;
            fault_next  = 1'b0;
         end
         ssc_pkg::OP_GATE_RET: begin
            esp_next    = IS_LEGACY ? arg_reg
                                    : {16'h0000, arg_reg[15:0]};
            mbytes_next = 4'h0;
            fault_next  = 1'b0;
         end
         ssc_pkg::OP_POP_MEM: begin
            // base taken after the pop, so a wrap lands at offset zero
            esp_next    = inc;
            maddr_next  = (db_reg ? inc : {16'h0000, inc[15:0]}) + arg_reg;
            mbytes_next = step[3:0];
            mdata_next  = arg_reg;
            fault_next  = 1'b0;
         end
         ssc_pkg::OP_NONE: begin
            fault_next = fault_reg;
         end
      endcase
   end

   // software-visible operand and stack registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         esp_reg    <= ssc_pkg::ESP_RST;
         arg_reg    <= 32'h0000_0000;
         aux_reg    <= 32'h0000_0000;
         cmd_reg    <= 4'h0;
         maddr_reg  <= 32'h0000_0000;
         mdata_reg  <= 32'h0000_0000;
         mbytes_reg <= 4'h0;
         fault_reg  <= 1'b0;
      end else if (ce) begin
         if (do_cmd) begin
            esp_reg    <= esp_next;
            cmd_reg    <= w_data_reg[3:0];
            maddr_reg  <= maddr_next;
            mdata_reg  <= mdata_next;
            mbytes_reg <= mbytes_next;
            fault_reg  <= fault_next;
         end else if (wr_fire && aw_addr_reg == ssc_pkg::OFS_ESP) begin
            esp_reg <= merge(esp_reg, w_data_reg, w_strb_reg);
         end
         if (wr_fire && aw_addr_reg == ssc_pkg::OFS_ARG) begin
            arg_reg <= merge(arg_reg, w_data_reg, w_strb_reg);
         end
         if (wr_fire && aw_addr_reg == ssc_pkg::OFS_AUX) begin
            aux_reg <= merge(aux_reg, w_data_reg, w_strb_reg);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control_reg_zero and paging switch

   // merged image of a control write, for the register and, in the later variant, the flag
   assign cr0_wr = merge(cr0_reg, w_data_reg, w_strb_reg);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cr0_reg <= ssc_pkg::CR0_RST;
         pg_reg  <= 1'b0;
      end else if (ce) begin
         if (wr_fire && aw_addr_reg == ssc_pkg::OFS_CR0) begin
            cr0_reg <= cr0_wr;
            if (IS_LATER) begin
               pg_reg <= cr0_wr[ssc_pkg::CR0_PG_BIT];
            end
         end else if (wr_fire && aw_addr_reg == ssc_pkg::OFS_NJMP) begin
            // older cores only switch on the following near jump
            pg_reg <= cr0_reg[ssc_pkg::CR0_PG_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // descriptor decode

   always_comb begin
      dhi_clear = (dhi_reg[31:16] == 16'h0000);
      // a clear top word reads the descriptor as a 16-bit one
      base_next = {dhi_clear ? 8'h00 : dhi_reg[31:24],
                   dhi_reg[7:0], dlo_reg[31:16]};
      lim20     = {dhi_clear ? 4'h0 : dhi_reg[19:16], dlo_reg[15:0]};
      if (!dhi_clear && dhi_reg[ssc_pkg::DHI_G_BIT]) begin
         limit_next = {lim20, 12'hFFF};
      end else begin
         limit_next = {12'h000, lim20};
      end
      if (dhi_clear || !dhi_reg[ssc_pkg::DHI_DB_BIT]) begin
         limit_next = (limit_next > 32'h0000_FFFF) ? 32'h0000_FFFF : limit_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dlo_reg         <= 32'h0000_0000;
         dhi_reg         <= 32'h0000_0000;
         base_reg        <= 32'h0000_0000;
         limit_reg       <= 32'h0000_0000;
         db_reg          <= 1'b0;
         wide_gate_reg   <= 1'b0;
         legacy_desc_reg <= 1'b0;
      end else if (ce) begin
         if (wr_fire && aw_addr_reg == ssc_pkg::OFS_DLO) begin
            dlo_reg <= merge(dlo_reg, w_data_reg, w_strb_reg);
         end
         if (wr_fire && aw_addr_reg == ssc_pkg::OFS_DHI) begin
            dhi_reg <= merge(dhi_reg, w_data_reg, w_strb_reg);
         end
         base_reg        <= base_next;
         limit_reg       <= limit_next;
         db_reg          <= !dhi_clear && dhi_reg[ssc_pkg::DHI_DB_BIT];
         // system descriptors: type bit 3 marks the 32-bit form
         wide_gate_reg   <= !dhi_reg[ssc_pkg::DHI_S_BIT]
                            && dhi_reg[ssc_pkg::DHI_WIDE_BIT];
         legacy_desc_reg <= dhi_clear;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_awready  = aw_rdy_reg;
   assign s_axi_wready   = w_rdy_reg;
   assign s_axi_bvalid   = bvalid_reg;
   assign s_axi_bresp    = bresp_reg;
   assign s_axi_arready  = ar_rdy_reg;
   assign s_axi_rvalid   = rvalid_reg;
   assign s_axi_rdata    = rdata_reg;
   assign s_axi_rresp    = rresp_reg;
   assign paging_on_flag = pg_reg;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_cmd(logic [2:0] c);
      ce && do_cmd && w_data_reg[2:0] == c;
   endsequence

   sequence s_cr0_write;
      ce && wr_fire && aw_addr_reg == ssc_pkg::OFS_CR0 && w_strb_reg[3];
   endsequence

   a_pg_follows: assert property (@(posedge sys_clk) disable iff (reset)
      s_cr0_write ##0 IS_LATER |=> pg_reg == $past(w_data_reg[31]))
      else $error("paging flag did not follow control write");

   a_pg_holds: assert property (@(posedge sys_clk) disable iff (reset)
      !IS_LATER && !(ce && wr_fire && aw_addr_reg == ssc_pkg::OFS_NJMP) |=> $stable(pg_reg))
      else $error("paging flag changed without near jump");

   a_sel_push: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h1) ##0 !fault_next
      |=> mbytes_reg == ((IS_ALT && $past(op32)) ? 4'h4 : 4'h2)
          && esp_reg == $past(dec))
      else $error("selector push size or pointer wrong");

   a_err_push: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h2) ##0 db_reg
      |=> mbytes_reg == (IS_LEGACY ? 4'h2 : 4'h4) && esp_reg == $past(esp_reg) - 32'h0000_0004
          && mdata_reg[31:16] == 16'h0000)
      else $error("error code push wrong");

   a_call_clean: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h6) ##0 IS_LATER && aux_reg[0] |=> mbytes_reg == 4'h0 && fault_reg)
      else $error("far call stored before branch check");

   a_fault_restore: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h6) ##0 aux_reg[0] |=> $stable(esp_reg))
      else $error("stack pointer not restored after branch fault");

   a_gate_save: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h7) |=> mdata_reg == {16'h0000, $past(esp_reg[15:0])} && mbytes_reg == 4'h2)
      else $error("gate call saved wrong pointer half");

   a_gate_ret: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h5) |=> esp_reg[31:16] == (IS_LEGACY ? $past(arg_reg[31:16]) : 16'h0000))
      else $error("return pointer upper half wrong");

   a_pop_wrap: assert property (@(posedge sys_clk) disable iff (reset)
      s_cmd(3'h4) ##0 !db_reg && inc[15:0] == 16'h0000 |=> maddr_reg == $past(arg_reg))
      else $error("wrapped pop-to-memory address wrong");

   a_desc_legacy: assert property (@(posedge sys_clk) disable iff (reset)
      ce && dhi_reg[31:16] == 16'h0000 ##1 ce
      |-> base_reg[31:24] == 8'h00 && limit_reg[31:16] == 16'h0000)
      else $error("legacy descriptor base or limit too wide");

endmodule

// ===== tb/ssc_desc_table.sv
/*
 * ssc_desc_table: two-entry descriptor table on the software side.
 * Assumes the bench copies the selected entry into the descriptor registers.
 */
`timescale 1ns/1ps
module ssc_desc_table (
   // lookup
   input  wire logic        idx,
   // descriptor words
   output logic [31:0]      dlo,
   output logic [31:0]      dhi
);
   // entry 0 keeps its top word clear, entry 1 is a wide stack with set top byte
   assign dlo = idx ? 32'h0000_FFFF : 32'h1234_5678;
   assign dhi = idx ? 32'h0140_0000 : 32'h0000_00AB;
endmodule

// ===== tb/stack_segment_compat_logic_bench.sv
/*
 * stack_segment_compat_logic_bench: self-checking bench for ssc_compat_core.
 * Assumes the default build variant and single-word AXI4-Lite transfers.
 */
`timescale 1ns/1ps
module stack_segment_compat_logic_bench;
   logic        sys_clk = 0, reset = 1, di = 0, awv = 0, wv = 0, arv = 0;
   logic        awr, wrr, bv, arr, rv, pg;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rnd = 32'h5DA7, e, rdd, lo, hi;
   logic [1:0]  br, rr;
   logic [33:0] eq[$], mq[$];
   int          mismatches = 0, checks_done = 0;
   ssc_desc_table ssc_desc_table_inst (.idx(di), .dlo(lo), .dhi(hi));
   ssc_compat_core ssc_compat_core_inst (.sys_clk(sys_clk), .reset(reset), .ce(1'b1),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(1'b1), .paging_on_flag(pg));
   // free-running 10 MHz clock
   initial forever #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input string n, input logic [33:0] s, input logic [33:0] x);
      checks_done++;
      if (s !== x) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   // one write; ready sampled mid-cycle so the release edge is never raced
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      @(posedge sys_clk);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
      fork
         begin do @(negedge sys_clk); while (!awr); @(posedge sys_clk); awv <= 1'b0; end
         begin do @(negedge sys_clk); while (!wrr); @(posedge sys_clk); wv <= 1'b0; end
      join
      do @(negedge sys_clk); while (!bv);
      chk("bresp", {32'h0, br}, {32'h0, r});
   endtask
   // one read; expectation noted first, monitor compares on arrival
   task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [33:0] m = 34'h3_FFFF_FFFF);
      eq.push_back(x & m);
      mq.push_back(m);
      @(posedge sys_clk);
      ara <= a; arv <= 1'b1;
      do @(negedge sys_clk); while (!arr);
      @(posedge sys_clk); arv <= 1'b0;
      do @(negedge sys_clk); while (!rv);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [31:0] p, input logic [31:0] a);
      wr(8'h08, p); wr(8'h0C, a); wr(8'h04, {28'h0, c});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // read monitor: rready is held high, so every rvalid edge is a transfer
   always @(posedge sys_clk) if (rv) chk("rdata", {rr, rdd} & mq.pop_front(), eq.pop_front());
   // watchdog, far beyond the roughly 140 cycles the sequence needs
   initial begin
      #500000; mismatches++; end_sim();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      wr(8'h00, 32'h8000_0000); chk("paging", {33'h0, pg}, 34'h1);
      wr(8'h30, 32'h0);
      wr(8'h00, 32'h0); chk("paging", {33'h0, pg}, 34'h0);
      rd(8'hFC, {2'h3, 32'h0});
      wr(8'h24, 32'h0, 2'h3);
      wr(8'h14, lo); wr(8'h18, hi);
      rd(8'h1C, 34'h00AB_1234);
      rd(8'h20, 34'h0000_5678);
      // let the table output settle before its words are copied
      di <= 1'b1;
      @(posedge sys_clk);
      wr(8'h14, lo); wr(8'h18, hi);
      rd(8'h1C, 34'h0100_0000); rd(8'h2C, 34'h80, 34'h3C0);
      rnd = xs(rnd);
      e = {16'h0, rnd[15:2], 2'h0} + 32'h100;
      cmd(4'h9, e, rnd); rd(8'h08, e - 32'h4); rd(8'h2C, 34'h2, 34'h2F);
      cmd(4'h2, e, rnd); rd(8'h08, e - 32'h4); rd(8'h2C, 34'h4, 34'h2F);
      rd(8'h28, {18'h0, rnd[15:0]});
      cmd(4'hB, e, rnd); rd(8'h08, e + 32'h4); rd(8'h2C, 34'h2, 34'h2F);
      cmd(4'h5, e, rnd); rd(8'h08, {18'h0, rnd[15:0]});
      wr(8'h10, 32'h1);
      cmd(4'hE, e, rnd); rd(8'h08, e); rd(8'h2C, 34'h20, 34'h2F);
      cmd(4'h7, rnd, 32'h0); rd(8'h28, {18'h0, rnd[15:0]});
      // back to the 16-bit stack: a wide pop from the top wraps to zero
      di <= 1'b0;
      @(posedge sys_clk);
      wr(8'h14, lo); wr(8'h18, hi);
      cmd(4'hC, 32'h0000_FFFC, rnd); rd(8'h24, {2'h0, rnd}); rd(8'h08, 34'h0);
      end_sim();
   end
endmodule
